// ==== logic/pamx_consts.svh ====
// Summary of operation
// - Global pull-up disable set keeps every port pull-up off regardless of direction and latch.
// - Each first-port pin doubles as matching external bus address/data bit zero to seven.
// - External memory enabled: first-port pull-up, direction, value come from overrides; no input override.
// - Address-active is asserted exactly while address bits sit on the multiplexed pins.
// - Second-port bit 7 outputs timer 2 compare/PWM when its direction bit is output.
// - Second-port bit 7 may instead carry timer 1 channel C, direction bit set to output.
// - Legacy compatibility mode removes timer 1 channel C from bit 7; only timer 2 remains.
// - Second-port bit 6 outputs timer 1 channel B compare/PWM when direction bit is one.
// - Second-port bit 5 outputs timer 1 channel A compare/PWM when direction bit is one.
// - Second-port bit 4 carries timer 0 compare/PWM output.
// - Second-port bits 3..0 carry SPI MISO, MOSI, SCK and slave select input.
// - Without pull-up override, pull-up on only for direction 0, latch 1, disable 0.
// - Value override set with driver on: pin drives override value instead of latch.
`ifndef PAMX_CONSTS_SVH
`define PAMX_CONSTS_SVH

// ============================================================
// Register byte offsets
`define PAMX_OFF_CTRL        8'h00
`define PAMX_OFF_PORTA_LATCH 8'h04
`define PAMX_OFF_PORTA_DIR   8'h08
`define PAMX_OFF_PORTA_PIN   8'h0c
`define PAMX_OFF_PORTB_LATCH 8'h10
`define PAMX_OFF_PORTB_DIR   8'h14
`define PAMX_OFF_PORTB_PIN   8'h18
`define PAMX_OFF_XM_STAT     8'h1c

// ============================================================
// Control register fields and reset values
`define PAMX_CTRL_T1C_SEL_BIT 1
`define PAMX_CTRL_PUD_BIT     2
`define PAMX_CTRL_XM_EN_BIT   7
`define PAMX_CTRL_RST         8'h00
`define PAMX_PORT_RST         8'h00

// ============================================================
// Bus constants
`define PAMX_HTRANS_NONSEQ 2'h2
`define PAMX_HSIZE_WORD    3'h2

// ============================================================
// External bus timing
`define PAMX_CLK_PERIOD_NS 10
`define PAMX_XM_ADDR_NS    20
`define PAMX_XM_DATA_NS    40
`define PAMX_XM_ADDR_CYC ((`PAMX_XM_ADDR_NS + `PAMX_CLK_PERIOD_NS - 1) / `PAMX_CLK_PERIOD_NS)
`define PAMX_XM_DATA_CYC ((`PAMX_XM_DATA_NS + `PAMX_CLK_PERIOD_NS - 1) / `PAMX_CLK_PERIOD_NS)

`endif

// ==== logic/pamx_pin_cell.sv ====
`timescale 1ns/10ps
module pamx_pin_cell (
	// Port register bits
	input  wire logic                dir,
	input  wire logic                latch,
	input  wire logic                global_pullup_disable,
	// Alternate function overrides
	input  wire pamx_pkg::pamx_ovr_t ovr,
	// Resulting pad controls
	output logic                     pull_en,
	output logic                     oe,
	output logic                     value
);
	import pamx_pkg::*;

	always_comb begin
		pull_en = ovr.pullup_override_enable ? ovr.pullup_override_value : (!dir && latch && !global_pullup_disable);
		oe     = ovr.direction_override_enable ? ovr.direction_override_value : dir;
		value  = ovr.value_override_enable ? ovr.value_override_value : latch;
	end
endmodule : pamx_pin_cell

// ==== logic/pamx_pkg.sv ====
package pamx_pkg;

	// ============================================================
	// Per-pin override set.
	typedef struct packed {
		logic pullup_override_enable;
		logic pullup_override_value;
		logic direction_override_enable;
		logic direction_override_value;
		logic value_override_enable;
		logic value_override_value;
	} pamx_ovr_t;

	// Drive of one 8-bit port towards the pads.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_en;
	} pamx_pin_drv_t;

	typedef enum logic [1:0] {
		XM_IDLE,
		XM_ADDR,
		XM_DATA
	} pamx_xm_state_t;

endpackage : pamx_pkg

// ==== logic/pamx_sync.sv ====
`timescale 1ns/10ps
module pamx_sync (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Asynchronous pin levels and their synchronised copies
	input  wire logic [15:0] async_in,
	output logic      [15:0] sync_out
);
	logic [15:0] meta_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q   <= 16'h0000;
			sync_out <= 16'h0000;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pamx_sync

// ==== logic/pamx_top.sv ====
`timescale 1ns/10ps
`include "pamx_consts.svh"
module pamx_top (
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// First port pads
	input  wire logic [7:0]            porta_pin_in,
	output pamx_pkg::pamx_pin_drv_t    porta_drv,
	// Second port pads
	input  wire logic [7:0]            portb_pin_in,
	output pamx_pkg::pamx_pin_drv_t    portb_drv,
	// External memory user side
	input  wire logic                  xm_req,
	input  wire logic                  xm_write,
	input  wire logic [7:0]            xm_addr,
	input  wire logic [7:0]            xm_wdata,
	output logic                       xm_busy,
	output logic                       xm_done,
	output logic      [7:0]            xm_rdata,
	// External memory strobes towards the pads
	output logic                       address_active_phase,
	output logic                       ext_mem_write_strobe,
	// Chip mode
	input  wire logic                  legacy_compat_mode,
	// Timer compare outputs and their enables
	input  wire logic                  timer2_compare_out,
	input  wire logic                  timer2_out_en,
	input  wire logic                  timer1_compare_c_out,
	input  wire logic                  timer1_c_out_en,
	input  wire logic                  timer1_compare_b_out,
	input  wire logic                  timer1_b_out_en,
	input  wire logic                  timer1_compare_a_out,
	input  wire logic                  timer1_a_out_en,
	input  wire logic                  timer0_compare_out,
	input  wire logic                  timer0_out_en,
	// Serial peripheral interface
	input  wire logic                  spi_enable,
	input  wire logic                  spi_master,
	input  wire logic                  spi_miso_out,
	input  wire logic                  spi_mosi_out,
	input  wire logic                  spi_sck_out,
	output logic                       spi_miso_in,
	output logic                       spi_mosi_in,
	output logic                       spi_sck_in,
	output logic                       spi_ss_n_in
);
	import pamx_pkg::*;

	// ============================================================
	// Register decode

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction : reg_hit

	logic [7:0]     ctrl_q;
	logic [7:0]     porta_latch_q;
	logic [7:0]     porta_dir_q;
	logic [7:0]     portb_latch_q;
	logic [7:0]     portb_dir_q;
	logic           wr_pend_q;
	logic [7:0]     wr_addr_q;
	logic [15:0]    pins_sync;
	logic [7:0]     porta_sync;
	logic [7:0]     portb_sync;
	pamx_xm_state_t xm_state_q;
	logic [2:0]     xm_cnt_q;
	logic           xm_wr_q;
	logic [7:0]     xm_addr_q;
	logic [7:0]     xm_wdata_q;
	logic [7:0]     rd_word;
	logic           ahb_take;
	logic           global_pullup_disable;
	logic           xm_en;

	assign global_pullup_disable        = ctrl_q[`PAMX_CTRL_PUD_BIT];
	assign xm_en      = ctrl_q[`PAMX_CTRL_XM_EN_BIT];
	assign porta_sync = pins_sync[7:0];
	assign portb_sync = pins_sync[15:8];
	assign ahb_take   = hsel && hready && (htrans == `PAMX_HTRANS_NONSEQ);

	// ============================================================
	// Pad input synchroniser

	pamx_sync u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in ({portb_pin_in, porta_pin_in}),
		.sync_out (pins_sync)
	);

	// ============================================================
	// AHB-Lite slave: zero wait states, always OKAY

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= ahb_take && hwrite && (hsize == `PAMX_HSIZE_WORD);
			wr_addr_q <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data is registered at the address phase so it stands in the data phase.
	always_comb begin
		rd_word = 8'h00;
		if (reg_hit(haddr[7:0], `PAMX_OFF_CTRL)) begin
			rd_word = ctrl_q;
		end else if (reg_hit(haddr[7:0], `PAMX_OFF_PORTA_LATCH)) begin
			rd_word = porta_latch_q;
		end else if (reg_hit(haddr[7:0], `PAMX_OFF_PORTA_DIR)) begin
			rd_word = porta_dir_q;
		end else if (reg_hit(haddr[7:0], `PAMX_OFF_PORTA_PIN)) begin
			rd_word = porta_sync;
		end else if (reg_hit(haddr[7:0], `PAMX_OFF_PORTB_LATCH)) begin
			rd_word = portb_latch_q;
		end else if (reg_hit(haddr[7:0], `PAMX_OFF_PORTB_DIR)) begin
			rd_word = portb_dir_q;
		end else if (reg_hit(haddr[7:0], `PAMX_OFF_PORTB_PIN)) begin
			rd_word = portb_sync;
		end else if (reg_hit(haddr[7:0], `PAMX_OFF_XM_STAT)) begin
			rd_word = {7'h00, xm_busy};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ahb_take && !hwrite) begin
			hrdata <= {24'h00_0000, rd_word};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `PAMX_CTRL_RST;
		end else if (wr_pend_q && reg_hit(wr_addr_q, `PAMX_OFF_CTRL)) begin
			ctrl_q <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			porta_latch_q <= `PAMX_PORT_RST;
			porta_dir_q   <= `PAMX_PORT_RST;
			portb_latch_q <= `PAMX_PORT_RST;
			portb_dir_q   <= `PAMX_PORT_RST;
		end else if (wr_pend_q) begin
			if (reg_hit(wr_addr_q, `PAMX_OFF_PORTA_LATCH)) begin
				porta_latch_q <= hwdata[7:0];
			end
			if (reg_hit(wr_addr_q, `PAMX_OFF_PORTA_DIR)) begin
				porta_dir_q <= hwdata[7:0];
			end
			if (reg_hit(wr_addr_q, `PAMX_OFF_PORTB_LATCH)) begin
				portb_latch_q <= hwdata[7:0];
			end
			if (reg_hit(wr_addr_q, `PAMX_OFF_PORTB_DIR)) begin
				portb_dir_q <= hwdata[7:0];
			end
		end
	end

	// ============================================================
	// External memory sequencer: address phase, then data phase

	logic xm_ada;
	logic xm_wr;

	assign xm_ada = (xm_state_q == XM_ADDR);
	assign xm_wr  = (xm_state_q == XM_DATA) && xm_wr_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xm_state_q <= XM_IDLE;
			xm_cnt_q   <= 3'h0;
			xm_wr_q    <= 1'b0;
			xm_addr_q  <= 8'h00;
			xm_wdata_q <= 8'h00;
		end else begin
			case (xm_state_q)
				XM_IDLE: begin
					// Requests while the bus is not enabled are ignored.
					if (xm_req && xm_en) begin
						xm_state_q <= XM_ADDR;
						xm_cnt_q   <= 3'h0;
						xm_wr_q    <= xm_write;
						xm_addr_q  <= xm_addr;
						xm_wdata_q <= xm_wdata;
					end
				end
				XM_ADDR: begin
					if (xm_cnt_q == 3'(`PAMX_XM_ADDR_CYC - 1)) begin
						xm_state_q <= XM_DATA;
						xm_cnt_q   <= 3'h0;
					end else begin
						xm_cnt_q <= xm_cnt_q + 3'h1;
					end
				end
				XM_DATA: begin
					if (xm_cnt_q == 3'(`PAMX_XM_DATA_CYC - 1)) begin
						xm_state_q <= XM_IDLE;
						xm_cnt_q   <= 3'h0;
					end else begin
						xm_cnt_q <= xm_cnt_q + 3'h1;
					end
				end
				default: begin
					xm_state_q <= XM_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xm_done  <= 1'b0;
			xm_busy  <= 1'b0;
			xm_rdata <= 8'h00;
		end else begin
			xm_busy <= (xm_state_q != XM_IDLE) || (xm_req && xm_en);
			xm_done <= (xm_state_q == XM_DATA) && (xm_cnt_q == 3'(`PAMX_XM_DATA_CYC - 1));
			// Read data comes back through the pad synchroniser.
			if ((xm_state_q == XM_DATA) && !xm_wr_q &&
				(xm_cnt_q == 3'(`PAMX_XM_DATA_CYC - 1))) begin
				xm_rdata <= porta_sync;
			end
		end
	end

	// ============================================================
	// Override generation

	pamx_ovr_t ovr_a [8];
	pamx_ovr_t ovr_b [8];
	logic      t1c_avail;
	logic      pb7_use_t1c;
	logic      spi_m;
	logic      spi_s;

	assign t1c_avail   = !legacy_compat_mode;
	assign pb7_use_t1c = t1c_avail && ctrl_q[`PAMX_CTRL_T1C_SEL_BIT];
	assign spi_m       = spi_enable && spi_master;
	assign spi_s       = spi_enable && !spi_master;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_porta_ovr
			always_comb begin
				ovr_a[gi].pullup_override_enable = xm_en;
				ovr_a[gi].pullup_override_value = !(xm_wr || xm_ada) && porta_latch_q[gi] && !global_pullup_disable;
				ovr_a[gi].direction_override_enable = xm_en;
				ovr_a[gi].direction_override_value = xm_wr || xm_ada;
				ovr_a[gi].value_override_enable = xm_en;
				ovr_a[gi].value_override_value = (xm_addr_q[gi] && xm_ada) || (xm_wdata_q[gi] && xm_wr);
			end
		end
	endgenerate

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			ovr_b[i] = '0;
		end
		ovr_b[7].value_override_enable = pb7_use_t1c ? timer1_c_out_en : timer2_out_en;
		ovr_b[7].value_override_value = pb7_use_t1c ? timer1_compare_c_out : timer2_compare_out;
		ovr_b[6].value_override_enable = timer1_b_out_en;
		ovr_b[6].value_override_value = timer1_compare_b_out;
		ovr_b[5].value_override_enable = timer1_a_out_en;
		ovr_b[5].value_override_value = timer1_compare_a_out;
		ovr_b[4].value_override_enable = timer0_out_en;
		ovr_b[4].value_override_value = timer0_compare_out;
		// Master forces data-in to input; slave forces data-out, clock and select to input.
		ovr_b[3].direction_override_enable = spi_m;
		ovr_b[3].value_override_enable = spi_s;
		ovr_b[3].value_override_value = spi_miso_out;
		ovr_b[2].direction_override_enable = spi_s;
		ovr_b[2].value_override_enable = spi_m;
		ovr_b[2].value_override_value = spi_mosi_out;
		ovr_b[1].direction_override_enable = spi_s;
		ovr_b[1].value_override_enable = spi_m;
		ovr_b[1].value_override_value = spi_sck_out;
		ovr_b[0].direction_override_enable = spi_s;
	end

	// ============================================================
	// Pin cells and registered pad drive

	pamx_pin_drv_t drv_a;
	pamx_pin_drv_t drv_b;

	generate
		for (gi = 0; gi < 8; gi++) begin : g_cells
			pamx_pin_cell u_cell_a (
				.dir    (porta_dir_q[gi]),
				.latch  (porta_latch_q[gi]),
				.global_pullup_disable    (global_pullup_disable),
				.ovr    (ovr_a[gi]),
				.pull_en (drv_a.pull_en[gi]),
				.oe     (drv_a.oe[gi]),
				.value  (drv_a.out[gi])
			);
			pamx_pin_cell u_cell_b (
				.dir    (portb_dir_q[gi]),
				.latch  (portb_latch_q[gi]),
				.global_pullup_disable    (global_pullup_disable),
				.ovr    (ovr_b[gi]),
				.pull_en (drv_b.pull_en[gi]),
				.oe     (drv_b.oe[gi]),
				.value  (drv_b.out[gi])
			);
		end
	endgenerate

	// Strobes are registered together with the pad drive so they stay aligned.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			porta_drv            <= '0;
			portb_drv            <= '0;
			address_active_phase <= 1'b0;
			ext_mem_write_strobe <= 1'b0;
		end else begin
			porta_drv            <= drv_a;
			portb_drv            <= drv_b;
			address_active_phase <= xm_ada;
			ext_mem_write_strobe <= xm_wr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			spi_miso_in <= 1'b0;
			spi_mosi_in <= 1'b0;
			spi_sck_in  <= 1'b0;
			spi_ss_n_in <= 1'b1;
		end else begin
			spi_miso_in <= portb_sync[3];
			spi_mosi_in <= portb_sync[2];
			spi_sck_in  <= portb_sync[1];
			spi_ss_n_in <= portb_sync[0];
		end
	end
endmodule : pamx_top

// ==== testbench/pamx_monitor.sv ====
`timescale 1ns/10ps
module pamx_monitor (
	// Clock and reset
	input wire logic                    hclk,
	input wire logic                    hresetn,
	// Observed outputs
	input wire pamx_pkg::pamx_pin_drv_t porta_drv,
	input wire logic                    address_active_phase,
	input wire logic                    ext_mem_write_strobe,
	input wire logic                    xm_busy,
	input wire logic                    xm_done
);
	import pamx_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ============================================================
	// External bus phases
	ada_len_a: assert property (
		$rose(address_active_phase) |-> address_active_phase [*2] ##1 !address_active_phase)
		else $error("address phase length wrong");
	wr_len_a: assert property (
		$rose(ext_mem_write_strobe) |-> ext_mem_write_strobe [*4] ##1 !ext_mem_write_strobe)
		else $error("write strobe length wrong");
	phase_excl_a: assert property (!(address_active_phase && ext_mem_write_strobe))
		else $error("address and write phases overlap");
	done_time_a: assert property (
		$rose(address_active_phase) |-> ##5 xm_done ##1 !xm_busy)
		else $error("transfer end misplaced");
	busy_len_a: assert property ($rose(xm_busy) |-> xm_busy [*7] ##1 !xm_busy)
		else $error("busy length wrong");
	done_pulse_a: assert property (xm_done |=> !xm_done)
		else $error("done longer than one cycle");

	// ============================================================
	// Pad drive during transfers
	ada_drive_a: assert property (address_active_phase |-> porta_drv.oe == 8'hff)
		else $error("address not driven");
	wr_drive_a: assert property (ext_mem_write_strobe |-> porta_drv.oe == 8'hff)
		else $error("write data not driven");
	rd_input_a: assert property (
		$fell(address_active_phase) && !ext_mem_write_strobe |-> porta_drv.oe == 8'h00 [*4])
		else $error("read pins driven");
	bus_pullup_a: assert property (
		address_active_phase || ext_mem_write_strobe |-> porta_drv.pull_en == 8'h00)
		else $error("pull-up on during bus drive");

	wr_cyc_c: cover property ($rose(ext_mem_write_strobe));
	rd_cyc_c: cover property ($fell(address_active_phase) && !ext_mem_write_strobe);
	pull_c: cover property (porta_drv.pull_en != 8'h00);
endmodule : pamx_monitor

bind pamx_top pamx_monitor i_pamx_monitor (.hclk, .hresetn, .porta_drv,
	.address_active_phase, .ext_mem_write_strobe, .xm_busy, .xm_done);

// ==== testbench/pamx_xm_model.sv ====
`timescale 1ns/10ps
module pamx_xm_model (
	// Clock
	input wire logic                    hclk,
	// First port pads
	input wire pamx_pkg::pamx_pin_drv_t drv,
	input wire logic                    ada,
	input wire logic                    wstb,
	output logic      [7:0]             pins
);
	import pamx_pkg::*;
	logic [7:0] mem [256];
	logic [7:0] addr_q;
	int         cnt = 0;

	initial pins = 8'h00;
	// A released bus shows a changing pattern, never the last value.
	always @(posedge hclk) begin
		if (ada) addr_q <= drv.out;
		if (wstb) mem[addr_q] <= drv.out;
		cnt <= ada ? 5 : (cnt > 0 ? cnt - 1 : 0);
	end

	// The memory answers soon after the pads are released, well before the next edge.
	always @(negedge hclk) begin
		pins <= (cnt > 0 && !ada && !wstb && drv.oe == 8'h00) ? mem[addr_q] : ~pins;
	end
endmodule : pamx_xm_model

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
module tb;
	import pamx_pkg::*;
	logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]   haddr, hwdata, hrdata;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [7:0]    porta_pin_in, portb_pin_in, xm_addr, xm_wdata, xm_rdata;
	pamx_pin_drv_t porta_drv, portb_drv;
	logic          xm_req, xm_write, xm_busy, xm_done, legacy_compat_mode;
	logic          address_active_phase, ext_mem_write_strobe;
	logic          timer2_compare_out, timer1_compare_c_out, timer1_compare_b_out;
	logic          timer1_compare_a_out, timer0_compare_out, timer2_out_en, timer1_c_out_en;
	logic          timer1_b_out_en, timer1_a_out_en, timer0_out_en;
	logic          spi_enable, spi_master, spi_miso_out, spi_mosi_out, spi_sck_out;
	logic          spi_miso_in, spi_mosi_in, spi_sck_in, spi_ss_n_in;
	int            error_cnt = 0;
	int            checks = 0;

	pamx_top i_pamx_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .porta_pin_in, .porta_drv, .portb_pin_in,
		.portb_drv, .xm_req, .xm_write, .xm_addr, .xm_wdata, .xm_busy, .xm_done, .xm_rdata,
		.address_active_phase, .ext_mem_write_strobe, .legacy_compat_mode,
		.timer2_compare_out, .timer2_out_en, .timer1_compare_c_out, .timer1_c_out_en,
		.timer1_compare_b_out, .timer1_b_out_en, .timer1_compare_a_out, .timer1_a_out_en,
		.timer0_compare_out, .timer0_out_en, .spi_enable, .spi_master, .spi_miso_out,
		.spi_mosi_out, .spi_sck_out, .spi_miso_in, .spi_mosi_in, .spi_sck_in, .spi_ss_n_in);

	pamx_xm_model i_pamx_xm_model (.hclk(hclk), .drv(porta_drv), .ada(address_active_phase),
		.wstb(ext_mem_write_strobe), .pins(porta_pin_in));

	// ============================================================
	// Common tasks
	task conclude;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge hclk);
	endtask : tick

	task ahb_addr(input logic [7:0] a, input logic w);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask : ahb_addr

	task ahb_wr(input logic [7:0] a, input logic [31:0] d);
		ahb_addr(a, 1'b1);
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : ahb_wr

	task ahb_rd(input logic [7:0] a, output logic [31:0] d);
		ahb_addr(a, 1'b0);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : ahb_rd

	task xm_go(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		xm_write <= w;
		xm_addr <= a;
		xm_wdata <= d;
		xm_req <= 1'b1;
		for (n = 0; n < 20 && xm_busy !== 1'b1; n++) @(posedge hclk);
		xm_req <= 1'b0;
		@(posedge hclk);
		chk("xm_addr", porta_drv.out, a);
		for (n = 0; n < 20 && xm_done !== 1'b1; n++) @(posedge hclk);
		chk("xm_done", xm_done, 1'b1);
		@(posedge hclk);
	endtask : xm_go

	// ============================================================
	// Scenarios
	task t_regs;
		logic [31:0] d;
		ahb_rd(8'h00, d);
		chk("ctrl_rst", d, 32'h0);
		ahb_rd(8'h20, d);
		chk("unmapped", d, 32'h0);
	endtask : t_regs

	task t_pullup;
		ahb_wr(8'h08, 32'h0f);
		ahb_wr(8'h04, 32'hff);
		tick(2);
		chk("pa_oe_pu", {porta_drv.oe, porta_drv.pull_en}, 16'h0ff0);
		ahb_wr(8'h00, 32'h04);
		tick(2);
		chk("pa_pud", porta_drv.pull_en, 8'h00);
		ahb_wr(8'h00, 32'h00);
	endtask : t_pullup

	task t_portb;
		ahb_wr(8'h14, 32'hff);
		ahb_wr(8'h10, 32'h00);
		{timer2_out_en, timer1_c_out_en, timer1_b_out_en, timer1_a_out_en, timer0_out_en}
			<= 5'h1f;
		{timer2_compare_out, timer1_compare_c_out, timer1_compare_b_out, timer1_compare_a_out,
			timer0_compare_out} <= 5'h15;
		for (int i = 0; i < 3; i++) begin
			ahb_wr(8'h00, (i != 0) ? 32'h02 : 32'h00);
			legacy_compat_mode <= (i == 2);
			tick(3);
			chk("pb7", portb_drv.out[7], (i == 1) ? 1'b0 : 1'b1);
			chk("pb6_4", portb_drv.out[6:4], 3'b101);
		end
		ahb_wr(8'h00, 32'h00);
		legacy_compat_mode <= 1'b0;
		{timer2_out_en, timer1_c_out_en, timer1_b_out_en, timer1_a_out_en, timer0_out_en}
			<= 5'h00;
		tick(3);
		chk("pb_latch", portb_drv.out[7:4], 4'h0);
	endtask : t_portb

	task t_spi;
		spi_enable <= 1'b1;
		spi_master <= 1'b1;
		spi_mosi_out <= 1'b1;
		spi_sck_out <= 1'b0;
		portb_pin_in <= 8'h09;
		tick(5);
		chk("spi_pads", {portb_drv.oe[3], portb_drv.out[2:1]}, 3'b010);
		chk("spi_in1", {spi_miso_in, spi_ss_n_in}, 2'b11);
		portb_pin_in <= 8'h00;
		tick(5);
		chk("spi_in0", {spi_miso_in, spi_ss_n_in}, 2'b00);
		spi_enable <= 1'b0;
	endtask : t_spi

	task t_xm;
		ahb_wr(8'h08, 32'h00);
		ahb_wr(8'h00, 32'h80);
		tick(2);
		chk("xm_idle", {porta_drv.oe, porta_drv.pull_en}, 16'h00ff);
		xm_go(1'b1, 8'h5a, 8'hc3);
		xm_go(1'b1, 8'ha5, 8'h3c);
		xm_go(1'b0, 8'h5a, 8'h00);
		chk("xm_rd0", xm_rdata, 8'hc3);
		xm_go(1'b0, 8'ha5, 8'h00);
		chk("xm_rd1", xm_rdata, 8'h3c);
		ahb_wr(8'h00, 32'h84);
		tick(2);
		chk("xm_pud", porta_drv.pull_en, 8'h00);
		ahb_wr(8'h00, 32'h00);
		xm_req <= 1'b1;
		tick(8);
		chk("xm_off", xm_busy, 1'b0);
		xm_req <= 1'b0;
	endtask : t_xm

	// ============================================================
	// Clock, reset, sequence and watchdog
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	initial begin
		#200000;
		error_cnt++;
		conclude();
	end

	initial begin
		{hresetn, hsel, hwrite, xm_req, xm_write, legacy_compat_mode} = '0;
		{haddr, hwdata, htrans, hsize, portb_pin_in, xm_addr, xm_wdata} = '0;
		hready = 1'b1;
		{timer2_compare_out, timer1_compare_c_out, timer1_compare_b_out} = '0;
		{timer1_compare_a_out, timer0_compare_out, timer2_out_en, timer1_c_out_en} = '0;
		{timer1_b_out_en, timer1_a_out_en, timer0_out_en} = '0;
		{spi_enable, spi_master, spi_miso_out, spi_mosi_out, spi_sck_out} = '0;
		tick(16);
		hresetn <= 1'b1;
		tick(2);
		t_regs();
		t_pullup();
		t_portb();
		t_spi();
		t_xm();
		conclude();
	end
endmodule : tb
